// file: design/bridge_acq_pkg.sv
// Shared constants, register map and carrier types for the bridge acquisition controller.
package bridge_acq_pkg;
   localparam int NUM_CH   = 8;
   localparam int SAMPLE_W = 24;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int RATE_W   = 16;
   localparam int CH_IDX_W = 3;

   // Clock rates in Hz; the local timebase is a fractional phase step of the system clock.
   localparam int SYS_CLK_HZ   = 20_000_000;
   localparam int LOCAL_TB_HZ  = 12_800_000;
   localparam int TB_GRAIN_HZ  = 100_000;
   localparam int TB_ACC_W     = 8;
   localparam logic [TB_ACC_W-1:0] TB_PHASE_INC = TB_ACC_W'(LOCAL_TB_HZ / TB_GRAIN_HZ);
   localparam logic [TB_ACC_W-1:0] TB_PHASE_MOD = TB_ACC_W'(SYS_CLK_HZ / TB_GRAIN_HZ);

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CFG       = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RATE      = 8'h08;
   localparam logic [ADDR_W-1:0] REG_ERR       = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_SHUNT     = 8'h10;
   localparam logic [ADDR_W-1:0] REG_CHAN_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] REG_STEP_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] REG_ZERO_BASE = 8'h60;
   localparam logic [ADDR_W-1:0] REG_BANK_MASK = 8'hE0;
   localparam int                WORD_LSB      = 2;

   // Field positions.
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT  = 1;
   localparam int CTRL_ACQ_BIT   = 0;

   // Reset values and error codes.
   localparam logic [RATE_W-1:0] RATE_DEFAULT     = 16'h0032;
   localparam logic [RATE_W-1:0] RATE_MIN         = 16'h0001;
   localparam logic [DATA_W-1:0] ERR_NONE         = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ERR_PROP_BUSY    = 32'h0001_0002;
   localparam logic [DATA_W-1:0] ERR_READ_TIMEOUT = 32'h0001_0003;
   localparam logic [1:0]        RESP_OKAY        = 2'h0;
   localparam logic [1:0]        RESP_SLVERR      = 2'h2;

   typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] samples_t;
   typedef logic [NUM_CH-1:0][DATA_W-1:0]   cal_words_t;

   typedef struct packed {
      logic share;
      logic follow;
      logic raw;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{share: 1'b0, follow: 1'b0, raw: 1'b0};

   typedef struct packed {
      logic     valid;
      samples_t data;
   } sample_bus_t;

   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_t;
endpackage : bridge_acq_pkg

// file: design/bridge_acq_ctrl.sv
// Acquisition controller: AXI4-Lite registers, timebase, rate divider and eight-channel sample stream.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
module bridge_acq_ctrl
   import bridge_acq_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_in,
   input  wire logic              sys_rst_in,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [DATA_W-1:0] s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [DATA_W-1:0]      s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   // Converter front end and calibration store
   input  wire samples_t          adc_code_in,
   input  wire samples_t          zero_code_in,
   input  wire cal_words_t        step_size_in,
   input  wire cal_words_t        zero_corr_in,
   // Timebase sharing
   input  wire logic              shared_tb_in,
   output logic                   share_tb_out,
   // Sample stream and status
   output sample_bus_t            sample_out,
   output logic [NUM_CH-1:0]      shunt_ctrl_out,
   output logic                   acquiring_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Shared timebase input synchroniser and local timebase.
   logic                tb_sync1_ff, tb_sync2_ff, tb_prev_ff;
   logic                share_tb_ff, nxt_share_tb;
   logic [TB_ACC_W-1:0] tb_acc_ff, nxt_tb_acc;
   logic [TB_ACC_W:0]   tb_sum;
   logic                local_tick, shared_tick, tb_tick;
   cfg_t                cfg_ff;
   always_comb begin
      tb_sum       = {1'b0, tb_acc_ff} + {1'b0, TB_PHASE_INC};
      local_tick   = (tb_sum >= {1'b0, TB_PHASE_MOD});
      nxt_tb_acc   = local_tick ? TB_ACC_W'(tb_sum - {1'b0, TB_PHASE_MOD}) : tb_sum[TB_ACC_W-1:0];
      shared_tick  = tb_sync2_ff & ~tb_prev_ff;
      tb_tick      = cfg_ff.follow ? shared_tick : local_tick;
      nxt_share_tb = local_tick & cfg_ff.share;
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tb_sync1_ff <= 1'b0;
         tb_sync2_ff <= 1'b0;
         tb_prev_ff  <= 1'b0;
         tb_acc_ff   <= '0;
         share_tb_ff <= 1'b0;
      end else begin
         tb_sync1_ff <= shared_tb_in;
         tb_sync2_ff <= tb_sync1_ff;
         tb_prev_ff  <= tb_sync2_ff;
         tb_acc_ff   <= nxt_tb_acc;
         share_tb_ff <= nxt_share_tb;
      end
   end

   assign share_tb_out = share_tb_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel output formatting.
   samples_t conv;
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_conv
         logic [SAMPLE_W:0] diff;
         assign diff = {adc_code_in[ch][SAMPLE_W-1], adc_code_in[ch]} -
                       {zero_code_in[ch][SAMPLE_W-1], zero_code_in[ch]};
         // Scaled words saturate instead of wrapping when subtracting the zero code pushes them out of range.
         assign conv[ch] = cfg_ff.raw ? adc_code_in[ch] :
                           (diff[SAMPLE_W] == diff[SAMPLE_W-1]) ? diff[SAMPLE_W-1:0] :
                           {diff[SAMPLE_W], {(SAMPLE_W-1){~diff[SAMPLE_W]}}};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers, write channel and acquisition state.
   logic              acq_ff, nxt_acq;
   logic [RATE_W-1:0] rate_ff, nxt_rate;
   logic [RATE_W-1:0] div_cnt_ff, nxt_div_cnt;
   cfg_t              nxt_cfg;
   logic [NUM_CH-1:0] shunt_ff, nxt_shunt;
   logic [DATA_W-1:0] err_ff, nxt_err;
   logic              aw_ff, nxt_aw, w_ff, nxt_w, bvalid_ff, nxt_bvalid;
   logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic [DATA_W-1:0] wdata_ff, nxt_wdata;
   logic [3:0]        wstrb_ff, nxt_wstrb;
   logic [1:0]        bresp_ff, nxt_bresp;
   sample_bus_t       sample_ff, nxt_sample;
   logic              wr_fire, stop_cmd, sample_tick, rd_timeout_evt, busy_evt;
   logic [RATE_W-1:0] wr_rate;

   assign s_axi_awready_out = ~aw_ff;
   assign s_axi_wready_out  = ~w_ff;
   assign wr_fire           = aw_ff & w_ff & ~bvalid_ff;
   assign stop_cmd          = wr_fire & (awaddr_ff == REG_CTRL) & wstrb_ff[0] & wdata_ff[CTRL_STOP_BIT];
   assign sample_tick       = acq_ff & ~stop_cmd & tb_tick & (div_cnt_ff == rate_ff - RATE_MIN);

   always_comb begin
      nxt_acq     = acq_ff;
      nxt_rate    = rate_ff;
      nxt_cfg     = cfg_ff;
      nxt_shunt   = shunt_ff;
      nxt_err     = err_ff;
      nxt_aw      = aw_ff;
      nxt_w       = w_ff;
      nxt_awaddr  = awaddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_wstrb   = wstrb_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_div_cnt = div_cnt_ff;
      busy_evt    = 1'b0;
      wr_rate     = {wstrb_ff[1] ? wdata_ff[15:8] : rate_ff[15:8], wstrb_ff[0] ? wdata_ff[7:0] : rate_ff[7:0]};

      if (acq_ff && tb_tick) begin
         nxt_div_cnt = sample_tick ? '0 : div_cnt_ff + RATE_MIN;
      end

      // Address and data are held separately so they may arrive in either order.
      if (s_axi_awvalid_in && !aw_ff) begin
         nxt_aw     = 1'b1;
         nxt_awaddr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_ff) begin
         nxt_w     = 1'b1;
         nxt_wdata = s_axi_wdata_in;
         nxt_wstrb = s_axi_wstrb_in;
      end
      if (bvalid_ff && s_axi_bready_in) begin
         nxt_bvalid = 1'b0;
      end

      if (wr_fire) begin
         nxt_aw     = 1'b0;
         nxt_w      = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp  = RESP_OKAY;
         case (awaddr_ff)
            REG_CTRL: begin
               if (wstrb_ff[0] && wdata_ff[CTRL_START_BIT]) begin
                  nxt_acq     = 1'b1;
                  nxt_div_cnt = '0;
               end
               if (wstrb_ff[0] && wdata_ff[CTRL_STOP_BIT]) begin
                  nxt_acq = 1'b0;
               end
            end
            REG_CFG: begin
               if (acq_ff) begin
                  busy_evt = 1'b1;
               end else if (wstrb_ff[0]) begin
                  nxt_cfg = cfg_t'(wdata_ff[$bits(cfg_t)-1:0]);
               end
            end
            REG_RATE: begin
               if (acq_ff) begin
                  busy_evt = 1'b1;
               end else begin
                  nxt_rate = (wr_rate == '0) ? RATE_MIN : wr_rate;
               end
            end
            REG_SHUNT: begin
               if (acq_ff) begin
                  busy_evt = 1'b1;
               end else if (wstrb_ff[0]) begin
                  nxt_shunt = wdata_ff[NUM_CH-1:0];
               end
            end
            REG_ERR: begin
               nxt_err = ERR_NONE;
            end
            default: begin
               nxt_bresp = RESP_SLVERR;
            end
         endcase
         if (busy_evt) begin
            nxt_bresp = RESP_SLVERR;
         end
      end

      // A refused write and a read timeout in the same cycle resolve by fixed order; no setting changes it.
      if (busy_evt) begin
         nxt_err = ERR_PROP_BUSY;
      end
      if (rd_timeout_evt) begin
         nxt_err = ERR_READ_TIMEOUT;
      end

      nxt_sample.valid = sample_tick;
      nxt_sample.data  = sample_tick ? conv : sample_ff.data;
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         acq_ff     <= 1'b0;
         rate_ff    <= RATE_DEFAULT;
         cfg_ff     <= CFG_RESET;
         shunt_ff   <= '0;
         err_ff     <= ERR_NONE;
         aw_ff      <= 1'b0;
         w_ff       <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         div_cnt_ff <= '0;
         sample_ff  <= '0;
      end else begin
         acq_ff     <= nxt_acq;
         rate_ff    <= nxt_rate;
         cfg_ff     <= nxt_cfg;
         shunt_ff   <= nxt_shunt;
         err_ff     <= nxt_err;
         aw_ff      <= nxt_aw;
         w_ff       <= nxt_w;
         awaddr_ff  <= nxt_awaddr;
         wdata_ff   <= nxt_wdata;
         wstrb_ff   <= nxt_wstrb;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         div_cnt_ff <= nxt_div_cnt;
         sample_ff  <= nxt_sample;
      end
   end

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out  = bresp_ff;
   assign sample_out       = sample_ff;
   assign shunt_ctrl_out   = shunt_ff;
   assign acquiring_out    = acq_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel.
   rd_state_t           rd_state_ff, nxt_rd_state;
   logic [DATA_W-1:0]   rdata_ff, nxt_rdata;
   logic [1:0]          rresp_ff, nxt_rresp;
   logic [CH_IDX_W-1:0] rd_ch_ff, nxt_rd_ch, ar_ch;

   assign s_axi_arready_out = (rd_state_ff == RD_IDLE);
   assign ar_ch             = s_axi_araddr_in[WORD_LSB +: CH_IDX_W];

   always_comb begin
      nxt_rd_state   = rd_state_ff;
      nxt_rdata      = rdata_ff;
      nxt_rresp      = rresp_ff;
      nxt_rd_ch      = rd_ch_ff;
      rd_timeout_evt = 1'b0;
      case (rd_state_ff)
         RD_IDLE: begin
            if (s_axi_arvalid_in) begin
               nxt_rd_state = RD_RESP;
               nxt_rresp    = RESP_OKAY;
               nxt_rdata    = '0;
               nxt_rd_ch    = ar_ch;
               if ((s_axi_araddr_in & REG_BANK_MASK) == REG_CHAN_BASE) begin
                  if (acq_ff) begin
                     nxt_rd_state = RD_WAIT;
                  end else begin
                     nxt_rresp      = RESP_SLVERR;
                     rd_timeout_evt = 1'b1;
                  end
               end else if ((s_axi_araddr_in & REG_BANK_MASK) == REG_STEP_BASE) begin
                  nxt_rdata = step_size_in[ar_ch];
               end else if ((s_axi_araddr_in & REG_BANK_MASK) == REG_ZERO_BASE) begin
                  nxt_rdata = zero_corr_in[ar_ch];
               end else begin
                  case (s_axi_araddr_in)
                     REG_CTRL:  nxt_rdata[CTRL_ACQ_BIT] = acq_ff;
                     REG_CFG:   nxt_rdata[$bits(cfg_t)-1:0] = cfg_ff;
                     REG_RATE:  nxt_rdata[RATE_W-1:0] = rate_ff;
                     REG_ERR:   nxt_rdata = err_ff;
                     REG_SHUNT: nxt_rdata[NUM_CH-1:0] = shunt_ff;
                     default:   nxt_rresp = RESP_SLVERR;
                  endcase
               end
            end
         end
         RD_WAIT: begin
            if (!acq_ff) begin
               nxt_rd_state   = RD_RESP;
               nxt_rresp      = RESP_SLVERR;
               rd_timeout_evt = 1'b1;
            end else if (sample_tick) begin
               nxt_rd_state = RD_RESP;
               nxt_rdata    = DATA_W'($signed(conv[rd_ch_ff]));
            end
         end
         RD_RESP: begin
            if (s_axi_rready_in) begin
               nxt_rd_state = RD_IDLE;
            end
         end
         default: begin
            nxt_rd_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_state_ff <= RD_IDLE;
         rdata_ff    <= '0;
         rresp_ff    <= RESP_OKAY;
         rd_ch_ff    <= '0;
      end else begin
         rd_state_ff <= nxt_rd_state;
         rdata_ff    <= nxt_rdata;
         rresp_ff    <= nxt_rresp;
         rd_ch_ff    <= nxt_rd_ch;
      end
   end

   assign s_axi_rvalid_out = (rd_state_ff == RD_RESP);
   assign s_axi_rdata_out  = rdata_ff;
   assign s_axi_rresp_out  = rresp_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_start_enters_acq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_fire && awaddr_ff == REG_CTRL && wstrb_ff[0] && wdata_ff[CTRL_START_BIT] && !wdata_ff[CTRL_STOP_BIT]
      |=> acq_ff ##1 (acq_ff || $past(wr_fire)))
      else $error("Start command did not enter acquisition.");
   a_false_start_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_fire && awaddr_ff == REG_CTRL && !wdata_ff[CTRL_START_BIT] && !wdata_ff[CTRL_STOP_BIT]
      |=> acq_ff == $past(acq_ff))
      else $error("False command changed the acquisition state.");
   a_stop_leaves_acq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_fire && awaddr_ff == REG_CTRL && wstrb_ff[0] && wdata_ff[CTRL_STOP_BIT]
      |=> !acq_ff && !sample_out.valid ##1 !sample_out.valid)
      else $error("Stop command did not end sampling.");
   a_false_stop_keeps: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      acq_ff && wr_fire && awaddr_ff == REG_CTRL && !wdata_ff[CTRL_STOP_BIT] |=> acq_ff)
      else $error("False stop command left acquisition.");
   a_rate_write_refused: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_fire && awaddr_ff == REG_RATE && acq_ff
      |=> $stable(rate_ff) && err_ff == ERR_PROP_BUSY && s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR)
      else $error("Rate write during acquisition was not refused.");
   a_raw_passes_code: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      sample_tick && cfg_ff.raw |=> sample_out.valid && sample_out.data == $past(adc_code_in))
      else $error("Raw sample differs from converter code.");
   a_rate_divides: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      sample_out.valid |-> $past(tb_tick) && $past(div_cnt_ff) == $past(rate_ff) - RATE_MIN)
      else $error("Sample produced off the divided timebase.");
   a_share_gated: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      share_tb_out |-> $past(cfg_ff.share) && $past(local_tick))
      else $error("Timebase offered while sharing is off.");
   a_read_waits_fresh: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      rd_state_ff == RD_WAIT && acq_ff && !sample_tick |=> !s_axi_rvalid_out)
      else $error("Channel read answered before a fresh sample.");
   a_read_times_out: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      rd_state_ff == RD_WAIT && !acq_ff |=> s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR
      && err_ff == ERR_READ_TIMEOUT)
      else $error("Waiting channel read did not time out.");
   a_idle_no_samples: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !acq_ff |=> !sample_out.valid)
      else $error("Sample produced outside acquisition.");
endmodule : bridge_acq_ctrl

// file: testbench/front_end_model.sv
// Behavioural converter front end, calibration store and leader timebase.
module front_end_model
   import bridge_acq_pkg::*;
(
   // Clock
   input  wire logic sys_clk_in,
   // Converter codes, calibration words and leader timebase
   output samples_t   adc_code_out,
   output samples_t   zero_code_out,
   output cal_words_t step_size_out,
   output cal_words_t zero_corr_out,
   output logic       leader_tb_out
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         adc_code_out[i]  = 24'h001000 + 24'(i);
         zero_code_out[i] = 24'h000010;
         step_size_out[i] = 32'hA000_0000 + 32'(i);
         zero_corr_out[i] = 32'hB000_0000 + 32'(i);
      end
   end
   // The leader's shared timebase rises every second clock.
   initial leader_tb_out = 1'b0;
   always @(posedge sys_clk_in) leader_tb_out <= ~leader_tb_out;
endmodule : front_end_model

// file: testbench/tb_top.sv
// Self-checking bench for the bridge acquisition controller over AXI4-Lite.
module tb_top
   import bridge_acq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, stb, acq, ltb;
   logic [3:0]  strb;
   logic [7:0]  awa, ara, shn;
   logic [31:0] wd, rdat, d;
   logic [1:0]  br, rr, r;
   sample_bus_t smp;
   samples_t    adc, zc;
   cal_words_t  stp, zcr;
   int          miscompares, n_compared;
   front_end_model front_end_model_i (.sys_clk_in(clk), .adc_code_out(adc), .zero_code_out(zc),
      .step_size_out(stp), .zero_corr_out(zcr), .leader_tb_out(ltb));
   bridge_acq_ctrl bridge_acq_ctrl_i (.sys_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(strb),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .adc_code_in(adc), .zero_code_in(zc), .step_size_in(stp), .zero_corr_in(zcr), .shared_tb_in(ltb),
      .share_tb_out(stb), .sample_out(smp), .shunt_ctrl_out(shn), .acquiring_out(acq));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Handshakes are judged at the falling edge, where ready and valid are settled for the next rise.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      logic at, dt, bt;
      int   t;
      bt = 1'b0;
      @(posedge clk);
      awa <= a;
      wd  <= dat;
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      for (t = 0; t < 3000 && !bt; t++) begin
         @(negedge clk);
         at   = awv & awr;
         dt   = wv & wrd;
         bt   = bv;
         resp = br;
         @(posedge clk);
         if (at) awv <= 1'b0;
         if (dt) wv <= 1'b0;
         if (bt) bry <= 1'b0;
      end
      if (!bt) chk("write response", 32'h1, 32'h0);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      logic at, rt;
      int   t;
      rt = 1'b0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      for (t = 0; t < 3000 && !rt; t++) begin
         @(negedge clk);
         at   = arv & arr;
         rt   = rv;
         dat  = rdat;
         resp = rr;
         @(posedge clk);
         if (at) arv <= 1'b0;
         if (rt) rry <= 1'b0;
      end
      if (!rt) chk("read response", 32'h1, 32'h0);
   endtask : axi_rd
   task automatic t_reset;
      chk("acquiring", 32'h0, 32'(acq));
      axi_rd(REG_RATE, d, r);
      chk("rate", 32'h0032, d);
      axi_rd(REG_ERR, d, r);
      chk("err", ERR_NONE, d);
   endtask : t_reset
   task automatic t_cmds;
      int n;
      axi_wr(REG_CTRL, 32'h0, r);
      chk("start false", 32'h0, 32'(acq));
      axi_wr(REG_RATE, 32'h2, r);
      axi_wr(REG_CTRL, 32'h1, r);
      chk("start true", 32'h1, 32'(acq));
      axi_wr(REG_CTRL, 32'h0, r);
      chk("stop false", 32'h1, 32'(acq));
      axi_wr(REG_RATE, 32'h5, r);
      chk("busy resp", 32'(RESP_SLVERR), 32'(r));
      axi_rd(REG_CHAN_BASE + 8'h0C, d, r);
      chk("scaled ch3", 32'h0000_0FF3, d);
      @(negedge clk);
      for (int t = 0; t < 100 && !smp.valid; t++) begin
         @(negedge clk);
      end
      chk("stream valid", 32'h1, 32'(smp.valid));
      chk("stream ch0", 32'h0000_0FF0, 32'(smp.data[0]));
      chk("stream ch7", 32'h0000_0FF7, 32'(smp.data[7]));
      axi_wr(REG_CTRL, 32'h2, r);
      chk("stop true", 32'h0, 32'(acq));
      n = 0;
      repeat (20) begin
         @(negedge clk);
         n += int'(smp.valid);
      end
      chk("samples after stop", 32'h0, 32'(n));
      axi_rd(REG_ERR, d, r);
      chk("err busy", ERR_PROP_BUSY, d);
      axi_rd(REG_RATE, d, r);
      chk("rate kept", 32'h2, d);
      axi_rd(REG_CHAN_BASE, d, r);
      chk("idle read", 32'(RESP_SLVERR), 32'(r));
      axi_rd(REG_ERR, d, r);
      chk("err timeout", ERR_READ_TIMEOUT, d);
   endtask : t_cmds
   task automatic t_stop_wait;
      logic [31:0] d2;
      logic [1:0]  r2;
      axi_wr(REG_ERR, 32'h0, r);
      axi_rd(REG_ERR, d2, r2);
      chk("err cleared", ERR_NONE, d2);
      axi_wr(REG_RATE, 32'hFFFF, r);
      axi_wr(REG_CTRL, 32'h1, r);
      fork
         axi_rd(REG_CHAN_BASE + 8'h08, d2, r2);
         begin
            repeat (8) @(posedge clk);
            axi_wr(REG_CTRL, 32'h2, r);
         end
      join
      chk("stop while waiting", 32'(RESP_SLVERR), 32'(r2));
      axi_rd(REG_ERR, d2, r2);
      chk("err wait timeout", ERR_READ_TIMEOUT, d2);
      axi_wr(REG_RATE, 32'h2, r);
   endtask : t_stop_wait
   task automatic t_modes;
      axi_wr(REG_CFG, 32'h1, r);
      axi_wr(REG_CTRL, 32'h1, r);
      axi_rd(REG_CHAN_BASE + 8'h1C, d, r);
      chk("raw ch7", 32'h0000_1007, d);
      axi_wr(REG_CTRL, 32'h2, r);
      axi_wr(REG_CFG, 32'h2, r);
      axi_wr(REG_CTRL, 32'h1, r);
      axi_rd(REG_CHAN_BASE + 8'h04, d, r);
      chk("follower ch1", 32'h0000_0FF1, d);
      axi_wr(REG_CTRL, 32'h2, r);
   endtask : t_modes
   task automatic t_props;
      axi_wr(REG_SHUNT, 32'hA5, r);
      chk("shunt", 32'hA5, 32'(shn));
      axi_rd(REG_STEP_BASE + 8'h14, d, r);
      chk("step ch5", 32'hA000_0005, d);
      axi_rd(REG_ZERO_BASE + 8'h18, d, r);
      chk("zero ch6", 32'hB000_0006, d);
      axi_wr(REG_STEP_BASE, 32'h1, r);
      chk("step write", 32'(RESP_SLVERR), 32'(r));
      axi_rd(8'h1C, d, r);
      chk("unmapped", 32'(RESP_SLVERR), 32'(r));
   endtask : t_props
   task automatic t_share;
      int n, m;
      n = 0;
      m = 0;
      repeat (50) begin
         @(negedge clk);
         m += int'(stb);
      end
      chk("unshared ticks", 32'd0, 32'(m));
      axi_wr(REG_CFG, 32'h4, r);
      repeat (3) @(negedge clk);
      repeat (50) begin
         @(negedge clk);
         n += int'(stb);
      end
      chk("shared ticks", 32'd32, 32'(n));
   endtask : t_share
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {rst, awv, wv, bry, arv, rry} = 6'b100000;
      {awa, ara, wd, strb} = '0;
      repeat (12) @(posedge clk);
      rst  <= 1'b0;
      strb <= 4'hF;
      t_reset();
      t_cmds();
      t_stop_wait();
      t_modes();
      t_props();
      t_share();
      tally_and_finish();
   end
endmodule : tb_top
